// ### design/cfgp_pkg.sv
// Constants, types and helpers of the configuration port block.
// Assumes a 40 MHz core clock; all counts derive from it.
package cfgp_pkg;

    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ         = 40;
    localparam int CLEAR_TIME_NS   = 2000;
    localparam int STARTUP_TIME_NS = 500;
    localparam int BUSY_TIME_NS    = 100;
    localparam int CONFIG_SHIFT_CLOCK_HALF_NS    = 250;
    localparam logic [7:0] CLEAR_CYC   = 8'((CLEAR_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] STARTUP_CYC = 8'((STARTUP_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] BUSY_CYC    = 8'((BUSY_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] CONFIG_SHIFT_CLOCK_HALF   = 8'((CONFIG_SHIFT_CLOCK_HALF_NS * CLK_MHZ + 999) / 1000);

    // ==========================================================
    // Mode codes and header length
    localparam logic [2:0] MODE_MASTER_SER = 3'h0;
    localparam logic [2:0] MODE_SLAVE_SER  = 3'h7;
    localparam logic [2:0] MODE_BYTE_PAR   = 3'h6;
    localparam logic [7:0] HDR_BITS        = 8'h20;

    // ==========================================================
    // Register map (byte addresses) and fields
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_LEN    = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_DATA   = 5'h0C;
    localparam int CTRL_KEEP_BIT    = 0;
    localparam int CTRL_DONE_OD_BIT = 1;
    localparam int CTRL_GCLK_LSB    = 4;
    localparam int CTRL_RESTART_BIT = 8;
    localparam int STAT_MODE_LSB    = 2;
    localparam int STAT_BUSY_BIT    = 5;
    localparam int STAT_COUNT_LSB   = 16;
    localparam int DATA_LAST_LSB    = 8;
    localparam logic [15:0] CTRL_RST = 16'h00F0;
    localparam logic [15:0] LEN_RST  = 16'h0010;

    typedef enum logic [1:0] {ST_CLEAR, ST_LOAD, ST_STARTUP, ST_USER} cfgp_state_t;

    function automatic logic cfgp_is_byte(input logic [2:0] m);
        return m == MODE_BYTE_PAR;
    endfunction

    function automatic logic cfgp_is_master(input logic [2:0] m);
        return m == MODE_MASTER_SER;
    endfunction

endpackage

// ### design/cfgp_sync2.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent slow level or clock pin.
`timescale 1ns/1ps
module cfgp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// ### design/cfgp_port.sv
// Configuration port of a programmable device: pins, load sequencer, registers.
// Assumes pins arrive asynchronous to core_clk and an Avalon-MM master on the bus.
//
// Function
// - Mode comes from the three mode pins, taken as memory clearing ends.
// - Config clock is input in serial-slave and byte modes, driven out in master.
// - After configuration the config clock is input only and ignored.
// - Low on the restart pin starts a fresh configuration.
// - Done pin shows loading finished and start-up running; may be open drain.
// - Clearing status pin is held low while memory is cleared.
// - Busy throttles byte acceptance in byte mode; host honours it.
// - In serial modes header bits are passed on the chain output.
// - In byte mode eight data pins carry configuration bytes in.
// - In serial modes one data input carries the bit stream.
// - Port pins revert to user I/O after configuration unless retained in byte mode; serial modes always revert.
// - Four global clock pads feed clock routing or act as user inputs.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module cfgp_port
    import cfgp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [2:0]  config_mode_select,
    input  wire logic        config_shift_clock_in,
    output logic             config_shift_clock_out,
    output logic             config_shift_clock_oe,
    input  wire logic        restart_req_n,
    input  wire logic        done_pin_in,
    output logic             done_pin_out,
    output logic             done_pin_oe,
    input  wire logic        mem_clear_n_in,
    output logic             mem_clear_n_out,
    output logic             mem_clear_n_oe,
    output logic             busy_dout_out,
    output logic             busy_dout_oe,
    input  wire logic [7:0]  parallel_cfg_data_in,
    output logic      [7:0]  parallel_cfg_data_out,
    output logic      [7:0]  parallel_cfg_data_oe,
    input  wire logic        cfg_write_n,
    input  wire logic        cfg_select_n,
    input  wire logic [3:0]  global_clock_pad,
    output logic      [3:0]  global_clock_route,
    output logic      [3:0]  global_user_in,
    input  wire logic [9:0]  user_pin_out,
    input  wire logic [9:0]  user_pin_oe,
    output logic      [10:0] user_pin_in,
    output logic      [7:0]  cfg_byte,
    output logic             cfg_byte_valid,
    output logic             config_done
);

    // ==========================================================
    // Pin synchronisers
    logic [20:0] sync_w;
    logic [3:0]  gclk_s;
    logic [2:0]  mode_s;
    logic [7:0]  data_s;
    logic        config_shift_clock_s, prog_s, wr_n_s, cs_n_s, done_s, init_s;

    cfgp_sync2 #(.W(21)) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .d        ({global_clock_pad, config_mode_select, config_shift_clock_in,
                    restart_req_n, parallel_cfg_data_in, cfg_write_n, cfg_select_n,
                    done_pin_in, mem_clear_n_in}),
        .q        (sync_w)
    );
    assign {gclk_s, mode_s, config_shift_clock_s, prog_s, data_s, wr_n_s, cs_n_s, done_s, init_s} = sync_w;

    // ==========================================================
    // State
    cfgp_state_t state_q, state_d;
    logic [2:0]  mode_q;
    logic [7:0]  tmr_q, tmr_d;
    logic [7:0]  div_q, busy_cnt_q, hdr_cnt_q;
    logic        mclk_q, config_shift_clock_prev_q, dout_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  shreg_q, sum_q;
    logic [15:0] byte_cnt_q, ctrl_q, len_q;
    logic        wait_q, sw_restart_q;

    // ==========================================================
    // Decode
    logic serial_w, master_w, loading_w, user_w, keep_w, od_w;
    logic config_shift_clock_rise_w, mclk_rise_w, div_end_w, bit_tick_w, accept_w, busy_w;
    logic byte_done_w, last_byte_w, restart_w, done_lvl_w;
    logic [7:0] new_byte_w;
    logic [3:0] gclk_use_w;

    assign serial_w    = !cfgp_is_byte(mode_q);
    assign master_w    = cfgp_is_master(mode_q);
    assign loading_w   = state_q == ST_LOAD;
    assign user_w      = state_q == ST_USER;
    assign keep_w      = ctrl_q[CTRL_KEEP_BIT] && !serial_w;
    assign od_w        = ctrl_q[CTRL_DONE_OD_BIT];
    assign gclk_use_w  = ctrl_q[CTRL_GCLK_LSB +: 4];
    assign div_end_w   = div_q == CONFIG_SHIFT_CLOCK_HALF - 8'h01;
    assign config_shift_clock_rise_w = config_shift_clock_s && !config_shift_clock_prev_q;
    assign mclk_rise_w = div_end_w && !mclk_q;
    assign bit_tick_w  = loading_w && serial_w
                         && (master_w ? mclk_rise_w : config_shift_clock_rise_w);
    assign busy_w      = busy_cnt_q != 8'h00;
    assign accept_w    = loading_w && !serial_w && config_shift_clock_rise_w
                         && !cs_n_s && !wr_n_s && !busy_w;
    assign new_byte_w  = serial_w ? {shreg_q[6:0], data_s[0]} : data_s;
    assign byte_done_w = serial_w ? (bit_tick_w && bit_cnt_q == 3'h7) : accept_w;
    assign last_byte_w = byte_done_w && (byte_cnt_q + 16'h0001 >= len_q);
    assign restart_w   = !prog_s || sw_restart_q;
    assign done_lvl_w  = state_q == ST_STARTUP || user_w;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q == 8'h00 ? 8'h00 : tmr_q - 8'h01;
        case (state_q)
            ST_CLEAR: begin
                if (tmr_q == 8'h00 && init_s) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (last_byte_w) begin
                    state_d = ST_STARTUP;
                    tmr_d   = STARTUP_CYC;
                end
            end
            ST_STARTUP: begin
                if (tmr_q == 8'h00 && done_s) begin
                    state_d = ST_USER;
                end
            end
            ST_USER: state_d = ST_USER;
            default: state_d = ST_CLEAR;
        endcase
        if (restart_w) begin
            state_d = ST_CLEAR;
            tmr_d   = CLEAR_CYC;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_CLEAR;
            tmr_q   <= CLEAR_CYC;
            mode_q  <= MODE_SLAVE_SER;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
            if (state_q == ST_CLEAR && state_d == ST_LOAD) begin
                mode_q <= mode_s;
            end
        end
    end

    // ==========================================================
    // Master clock divider, edge finder, busy throttle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_q       <= 8'h00;
            mclk_q      <= 1'b0;
            config_shift_clock_prev_q <= 1'b0;
            busy_cnt_q  <= 8'h00;
        end else begin
            div_q       <= div_end_w ? 8'h00 : div_q + 8'h01;
            mclk_q      <= (loading_w && master_w) ? (mclk_q ^ div_end_w) : 1'b0;
            config_shift_clock_prev_q <= config_shift_clock_s;
            if (accept_w) begin
                busy_cnt_q <= BUSY_CYC;
            end else if (busy_w) begin
                busy_cnt_q <= busy_cnt_q - 8'h01;
            end
        end
    end

    // ==========================================================
    // Data path: serial shift, header forward, byte output
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shreg_q    <= 8'h00;
            bit_cnt_q  <= 3'h0;
            hdr_cnt_q  <= 8'h00;
            dout_q     <= 1'b0;
            byte_cnt_q <= 16'h0000;
            sum_q      <= 8'h00;
            cfg_byte   <= 8'h00;
        end else if (state_q == ST_CLEAR) begin
            bit_cnt_q  <= 3'h0;
            hdr_cnt_q  <= 8'h00;
            byte_cnt_q <= 16'h0000;
            sum_q      <= 8'h00;
        end else begin
            if (bit_tick_w) begin
                shreg_q   <= new_byte_w;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (hdr_cnt_q < HDR_BITS) begin
                    dout_q    <= data_s[0];
                    hdr_cnt_q <= hdr_cnt_q + 8'h01;
                end
            end
            if (byte_done_w) begin
                cfg_byte   <= new_byte_w;
                byte_cnt_q <= byte_cnt_q + 16'h0001;
                sum_q      <= sum_q ^ new_byte_w;
            end
        end
    end

    // ==========================================================
    // Pin drivers
    logic       config_shift_clock_oe_d, done_out_d, done_oe_d, init_out_d, init_oe_d;
    logic       bd_out_d, bd_oe_d, port_user_w;
    logic [7:0] d_out_d, d_oe_d;

    assign port_user_w = user_w && !keep_w;
    assign config_shift_clock_oe_d   = loading_w && master_w;
    assign done_out_d  = od_w ? 1'b0 : done_lvl_w;
    assign done_oe_d   = od_w ? !done_lvl_w : 1'b1;
    assign init_out_d  = user_w ? user_pin_out[9] : 1'b0;
    assign init_oe_d   = user_w ? user_pin_oe[9]
                       : (state_q == ST_CLEAR && tmr_q != 8'h00);
    assign bd_out_d    = port_user_w ? user_pin_out[8]
                       : (serial_w ? dout_q : busy_w);
    assign bd_oe_d     = port_user_w ? user_pin_oe[8] : (loading_w || user_w);
    assign d_out_d     = port_user_w ? user_pin_out[7:0] : 8'h00;
    assign d_oe_d      = port_user_w ? user_pin_oe[7:0] : 8'h00;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            config_shift_clock_out <= 1'b0;
            config_shift_clock_oe  <= 1'b0;
            done_pin_out           <= 1'b0;
            done_pin_oe            <= 1'b1;
            mem_clear_n_out        <= 1'b0;
            mem_clear_n_oe         <= 1'b1;
            busy_dout_out          <= 1'b0;
            busy_dout_oe           <= 1'b0;
            parallel_cfg_data_out  <= 8'h00;
            parallel_cfg_data_oe   <= 8'h00;
            global_clock_route     <= 4'h0;
            global_user_in         <= 4'h0;
            user_pin_in            <= 11'h000;
            cfg_byte_valid         <= 1'b0;
            config_done            <= 1'b0;
        end else begin
            config_shift_clock_out <= mclk_q;
            config_shift_clock_oe  <= config_shift_clock_oe_d;
            done_pin_out           <= done_out_d;
            done_pin_oe            <= done_oe_d;
            mem_clear_n_out        <= init_out_d;
            mem_clear_n_oe         <= init_oe_d;
            busy_dout_out          <= bd_out_d;
            busy_dout_oe           <= bd_oe_d;
            parallel_cfg_data_out  <= d_out_d;
            parallel_cfg_data_oe   <= d_oe_d;
            global_clock_route     <= gclk_s & gclk_use_w;
            global_user_in         <= gclk_s & ~gclk_use_w;
            user_pin_in            <= port_user_w ? {cs_n_s, wr_n_s, init_s, data_s}
                                                  : 11'h000;
            cfg_byte_valid         <= byte_done_w;
            config_done            <= user_w;
        end
    end

    // ==========================================================
    // Avalon-MM slave, one wait state
    logic        sel_ctrl_w, sel_len_w, wr_go_w;
    logic [31:0] rd_mux_w;

    function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
        return {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
    endfunction

    assign sel_ctrl_w = avs_address[4:2] == REG_CTRL[4:2];
    assign sel_len_w  = avs_address[4:2] == REG_LEN[4:2];
    assign wr_go_w    = avs_write && !wait_q;
    assign rd_mux_w   =
        sel_ctrl_w ? {16'h0000, ctrl_q} :
        sel_len_w  ? {16'h0000, len_q} :
        avs_address[4:2] == REG_STATUS[4:2] ?
            {byte_cnt_q, 10'h000, busy_w, mode_q, state_q} :
        avs_address[4:2] == REG_DATA[4:2] ? {16'h0000, cfg_byte, sum_q} : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_q       <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ctrl_q       <= CTRL_RST;
            len_q        <= LEN_RST;
            sw_restart_q <= 1'b0;
        end else begin
            wait_q       <= !((avs_read || avs_write) && wait_q);
            sw_restart_q <= 1'b0;
            if (avs_read && wait_q) begin
                avs_readdata <= rd_mux_w;
            end
            if (wr_go_w && sel_ctrl_w) begin
                ctrl_q       <= be_merge(ctrl_q, avs_writedata, avs_byteenable)
                                & ~(16'h0001 << CTRL_RESTART_BIT);
                sw_restart_q <= avs_byteenable[1] && avs_writedata[CTRL_RESTART_BIT];
            end
            if (wr_go_w && sel_len_w) begin
                len_q <= be_merge(len_q, avs_writedata, avs_byteenable);
            end
        end
    end
    assign avs_waitrequest = wait_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_mode_held_load: assert property (loading_w && $past(loading_w) |-> $stable(mode_q))
        else $error("mode changed during load");
    a_config_shift_clock_drive_dir: assert property (config_shift_clock_oe ==
                                       $past(loading_w && master_w))
        else $error("config clock direction wrong");
    a_config_shift_clock_user_ign: assert property (user_w [*2] |-> !config_shift_clock_oe && !bit_tick_w
                                      && !accept_w)
        else $error("config clock used after configuration");
    a_restart_clear: assert property (!prog_s |=> state_q == ST_CLEAR ##1 mem_clear_n_oe)
        else $error("restart did not clear");
    a_done_startup: assert property (state_q == ST_STARTUP [*2] |-> (!done_pin_oe || done_pin_out)
                                     && !(done_pin_oe && od_w))
        else $error("done pin not released in start-up");
    a_init_low_clr: assert property ((state_q == ST_CLEAR && tmr_q != 8'h00) [*2] |->
                                     mem_clear_n_oe && !mem_clear_n_out)
        else $error("clearing status not low");
    a_busy_throttle: assert property (accept_w |=> busy_w [*4] ##1 !busy_w)
        else $error("busy window wrong");
    a_hdr_forward: assert property (bit_tick_w && hdr_cnt_q < HDR_BITS |=>
                                    dout_q == $past(data_s[0]))
        else $error("header bit not forwarded");
    a_byte_capture: assert property (accept_w |=> cfg_byte_valid && cfg_byte == $past(data_s))
        else $error("parallel byte not captured");
    a_serial_byte: assert property (bit_tick_w && bit_cnt_q == 3'h7 |=> cfg_byte_valid
                                    && cfg_byte[0] == $past(data_s[0]))
        else $error("serial byte not assembled");
    a_pins_revert: assert property (port_user_w [*2] |->
                                    parallel_cfg_data_oe == $past(user_pin_oe[7:0]))
        else $error("data pins not returned to user");
    a_gclk_route: assert property (global_clock_route == ($past(gclk_s) & $past(gclk_use_w)))
        else $error("global clock routing wrong");

    c_byte_load: cover property (loading_w && !serial_w ##1 state_q == ST_STARTUP);
    c_master_load: cover property (loading_w && master_w ##1 state_q == ST_STARTUP);
    c_reach_user: cover property (state_q == ST_STARTUP ##1 user_w);
    c_restart_load: cover property (loading_w && !prog_s);

endmodule

// ### testbench/cfgp_host_model.sv
// Host model: drives the config clock, data, write strobe and select pins.
// Assumes core_clk from the bench; one config clock period is 8 core cycles.
`timescale 1ns/1ps
module cfgp_host_model (
    input  wire logic  core_clk,
    input  wire logic  busy_dout_out,
    input  wire logic  busy_dout_oe,
    output logic       config_shift_clock_in,
    output logic [7:0] parallel_cfg_data_in,
    output logic       cfg_write_n,
    output logic       cfg_select_n
);
    // ==========================================================
    // Idle levels; the clock stands low outside frames
    initial begin
        config_shift_clock_in = 1'b0;
        parallel_cfg_data_in  = 8'h00;
        cfg_write_n           = 1'b1;
        cfg_select_n          = 1'b1;
    end

    // ==========================================================
    // Transfers; data held 4 core cycles before and after each rise
    task automatic tick();
        repeat (4) @(posedge core_clk);
        config_shift_clock_in <= 1'b1;
        repeat (4) @(posedge core_clk);
        config_shift_clock_in <= 1'b0;
    endtask

    task automatic send_par(input logic [7:0] b);
        int n;
        n = 0;
        while (busy_dout_oe === 1'b1 && busy_dout_out !== 1'b0 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        parallel_cfg_data_in <= b;
        cfg_write_n          <= 1'b0;
        cfg_select_n         <= 1'b0;
        tick();
        cfg_write_n          <= 1'b1;
        cfg_select_n         <= 1'b1;
        parallel_cfg_data_in <= ~b;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic send_ser(input logic [7:0] b, output logic [7:0] chain);
        for (int i = 7; i >= 0; i--) begin
            @(posedge core_clk);
            parallel_cfg_data_in[0] <= b[i];
            tick();
            repeat (2) @(posedge core_clk);
            chain[i] = busy_dout_out;
        end
        @(posedge core_clk);
        parallel_cfg_data_in[0] <= ~b[0];
    endtask
endmodule

// ### testbench/fpga_config_port_pins_tb.sv
// Bench for the configuration port: Avalon tasks, host pin model, byte monitor.
// Assumes cfgp_port and cfgp_host_model; core clock 40 MHz, link clock 200 ns.
`timescale 1ns/1ps
module fpga_config_port_pins_tb;
    import cfgp_pkg::*;
    // ==========================================================
    // Signals, wired pins and bookkeeping
    logic        core_clk = 1'b0;
    logic        rstn, avs_read, avs_write, avs_waitrequest, config_shift_clock_in;
    logic        config_shift_clock_out, config_shift_clock_oe, restart_req_n, v;
    logic        done_pin_out, done_pin_oe, mem_clear_n_out, mem_clear_n_oe;
    logic        busy_dout_out, busy_dout_oe, cfg_write_n, cfg_select_n;
    logic        cfg_byte_valid, config_done, done_pin_in, mem_clear_n_in;
    logic [2:0]  config_mode_select;
    logic [3:0]  avs_byteenable, global_clock_pad, global_clock_route, global_user_in;
    logic [4:0]  avs_address;
    logic [7:0]  parallel_cfg_data_in, parallel_cfg_data_out, parallel_cfg_data_oe;
    logic [7:0]  cfg_byte, b0, b1, chain;
    logic [9:0]  user_pin_out, user_pin_oe;
    logic [10:0] user_pin_in;
    logic [15:0] lfsr = 16'hEE42;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0]  exp_q[$];
    int          num_errors = 0;
    int          compares = 0;

    assign done_pin_in    = done_pin_oe ? done_pin_out : 1'b1;
    assign mem_clear_n_in = (mem_clear_n_oe && !mem_clear_n_out) ? 1'b0 : 1'b1;
    always #12.5 core_clk = ~core_clk;

    cfgp_port dut (
        .core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .config_mode_select,
        .config_shift_clock_in, .config_shift_clock_out, .config_shift_clock_oe,
        .restart_req_n, .done_pin_in, .done_pin_out, .done_pin_oe, .mem_clear_n_in,
        .mem_clear_n_out, .mem_clear_n_oe, .busy_dout_out, .busy_dout_oe,
        .parallel_cfg_data_in, .parallel_cfg_data_out, .parallel_cfg_data_oe,
        .cfg_write_n, .cfg_select_n, .global_clock_pad, .global_clock_route,
        .global_user_in, .user_pin_out, .user_pin_oe, .user_pin_in, .cfg_byte,
        .cfg_byte_valid, .config_done
    );
    cfgp_host_model host (
        .core_clk, .busy_dout_out, .busy_dout_oe, .config_shift_clock_in,
        .parallel_cfg_data_in, .cfg_write_n, .cfg_select_n
    );

    // ==========================================================
    // Helpers: compare, random source, bus cycle, state poll, verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) num_errors++;
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        do begin
            bus(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[1:0] !== s && n < 300);
        if (rd[1:0] !== s) num_errors++;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // Byte monitor, watchdog and main sequence
    always @(posedge core_clk) begin
        if (cfg_byte_valid === 1'b1 && exp_q.size() == 0)
            check("unexpected byte", 32'h1, 32'h0);
        else if (cfg_byte_valid === 1'b1)
            check("cfg_byte", {24'h0, cfg_byte}, {24'h0, exp_q.pop_front()});
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        complete_run();
    end

    initial begin
        rstn               = 1'b0;
        avs_read           = 1'b0;
        avs_write          = 1'b0;
        avs_address        = 5'h00;
        avs_writedata      = 32'h0;
        avs_byteenable     = 4'hF;
        config_mode_select = MODE_BYTE_PAR;
        restart_req_n      = 1'b1;
        global_clock_pad   = 4'h0;
        user_pin_out       = 10'h000;
        user_pin_oe        = 10'h000;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        bus(1'b0, REG_CTRL, 32'h0);
        check("ctrl reset", rd, {16'h0, CTRL_RST});
        bus(1'b0, REG_LEN, 32'h0);
        check("len reset", rd, {16'h0, LEN_RST});
        bus(1'b1, 5'h10, 32'hFFFF);
        bus(1'b0, 5'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, REG_LEN, 32'h2);
        $display("Test registers done");
        wait_state(2'h1);
        check("mode byte", {29'h0, rd[4:2]}, {29'h0, MODE_BYTE_PAR});
        check("clock oe byte", {31'h0, config_shift_clock_oe}, 32'h0);
        b0 = rnd();
        b1 = rnd();
        exp_q.push_back(b0);
        exp_q.push_back(b1);
        host.send_par(b0);
        host.send_par(b1);
        wait_state(2'h3);
        check("done pin", {30'h0, done_pin_oe, done_pin_out}, 32'h3);
        bus(1'b0, REG_DATA, 32'h0);
        check("data reg", {16'h0, rd[15:0]}, {16'h0, b1, b0 ^ b1});
        user_pin_out     <= {2'h2, rnd()};
        user_pin_oe      <= {2'h2, rnd()};
        global_clock_pad <= 4'hA;
        repeat (5) @(posedge core_clk);
        check("user out", {12'h0, mem_clear_n_oe, busy_dout_oe, parallel_cfg_data_oe,
              mem_clear_n_out, busy_dout_out, parallel_cfg_data_out},
              {12'h0, user_pin_oe, user_pin_out});
        check("user in", {21'h0, user_pin_in}, {21'h0, cfg_select_n, cfg_write_n,
              mem_clear_n_in, parallel_cfg_data_in});
        check("gclk", {24'h0, global_clock_route, global_user_in}, 32'hA0);
        host.send_par(rnd());
        check("still done", {31'h0, config_done}, 32'h1);
        bus(1'b1, REG_CTRL, 32'h30);
        repeat (5) @(posedge core_clk);
        check("gclk split", {24'h0, global_clock_route, global_user_in}, 32'h28);
        $display("Test byte load done");
        config_mode_select <= MODE_SLAVE_SER;
        restart_req_n      <= 1'b0;
        repeat (6) @(posedge core_clk);
        check("clearing", {30'h0, mem_clear_n_oe, mem_clear_n_out}, 32'h2);
        restart_req_n <= 1'b1;
        bus(1'b1, REG_LEN, 32'h4);
        wait_state(2'h1);
        check("mode serial", {29'h0, rd[4:2]}, {29'h0, MODE_SLAVE_SER});
        for (int i = 0; i < 4; i++) begin
            b0 = rnd();
            exp_q.push_back(b0);
            host.send_ser(b0, chain);
            check("chain out", {24'h0, chain}, {24'h0, b0});
        end
        wait_state(2'h3);
        $display("Test serial load done");
        config_mode_select <= MODE_MASTER_SER;
        bus(1'b1, REG_CTRL, 32'h1F2);
        wait_state(2'h1);
        check("clock oe master", {31'h0, config_shift_clock_oe}, 32'h1);
        v = config_shift_clock_out;
        repeat (10) @(posedge core_clk);
        check("clock toggles", {31'h0, config_shift_clock_out}, {31'h0, ~v});
        repeat (4) exp_q.push_back({8{parallel_cfg_data_in[0]}});
        wait_state(2'h3);
        check("done open drain", {30'h0, done_pin_oe, done_pin_out}, 32'h0);
        $display("Test master clock done");
        complete_run();
    end
endmodule
